// *** src/sep_pkg.sv ***
package sep_pkg;
	// ----------------------------------------
	// instruction codes
	// ----------------------------------------
	localparam logic [7:0] OP_SET_WL   = 8'h06;
	localparam logic [7:0] OP_CLR_WL   = 8'h04;
	localparam logic [7:0] OP_RD_STAT  = 8'h05;
	localparam logic [7:0] OP_WR_STAT  = 8'h01;
	localparam logic [7:0] OP_RD_ARR   = 8'h03;
	localparam logic [7:0] OP_WR_ARR   = 8'h02;
	localparam logic [7:0] OP_RD_IDENT = 8'h83;
	localparam logic [7:0] OP_WR_IDENT = 8'h82;
	// ----------------------------------------
	// status byte layout
	// ----------------------------------------
	localparam int BIT_BUSY    = 0;
	localparam int BIT_PERMIT  = 1;
	localparam int BIT_PROT_LO = 2;
	localparam int BIT_PROT_HI = 3;
	localparam int BIT_LOCK    = 7;
	localparam int ADDR_SEL    = 10;
	// ----------------------------------------
	// protection bounds and id page
	// ----------------------------------------
	localparam logic [10:0] PROT_QUARTER = 11'h600;
	localparam logic [10:0] PROT_HALF    = 11'h400;
	localparam logic [1:0]  BP_ALL       = 2'h3;
	localparam int          ARR_WORDS    = 2048;
	localparam int          PAGE_BYTES   = 32;
	// identification codes: values are arbitrary
	localparam logic [7:0]  ID_MAKER     = 8'h5a;
	localparam logic [7:0]  ID_FAMILY    = 8'h11;
	localparam logic [7:0]  ID_DENSITY   = 8'h22;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 25;
	localparam int WRITE_CYCLE_NS  = 4000000;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_NS / CLK_PERIOD_NS;
	localparam int SCLK_PERIOD_NS  = 200;
	localparam int SCLK_HALF_CYC   = SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	// ----------------------------------------
	// host register map
	// ----------------------------------------
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_TX   = 2'h1;
	localparam logic [1:0] REG_RX   = 2'h2;
	localparam logic [1:0] REG_STAT = 2'h3;
	localparam int CTRL_KEEP = 0;
	localparam int CTRL_CPOL = 1;
	localparam int CTRL_HOLD = 2;
	localparam int CTRL_WP   = 3;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PH_OP   = 3'b000,
		PH_ADDR = 3'b001,
		PH_DATA = 3'b010,
		PH_OUT  = 3'b011,
		PH_WAIT = 3'b100,
		PH_DONE = 3'b101
	} sep_phase_e;
	typedef enum logic [3:0] {
		K_NONE  = 4'b0000,
		K_SETWL = 4'b0001,
		K_CLRWL = 4'b0010,
		K_RDST  = 4'b0011,
		K_WRST  = 4'b0100,
		K_RDARR = 4'b0101,
		K_WRARR = 4'b0110,
		K_RDPG  = 4'b0111,
		K_WRPG  = 4'b1000,
		K_RDLK  = 4'b1001,
		K_LOCK  = 4'b1010
	} sep_kind_e;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LO   = 2'b01,
		H_HI   = 2'b10,
		H_END  = 2'b11
	} sep_hstate_e;
endpackage

// *** src/sep_spi_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sep_spi_if;
	logic csN;
	logic sclk;
	logic mosi;
	logic misoOut;
	logic misoOen;
	logic holdN;
	logic wpN;
	logic miso;
	// released line reads high
	assign miso = misoOen ? 1'b1 : misoOut;
	modport device (input csN, sclk, mosi, holdN, wpN, output misoOut, misoOen);
	modport host (output csN, sclk, mosi, holdN, wpN, input miso);
endinterface
`default_nettype wire

// *** src/sep_eeprom_dev.sv ***
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_dev #(
	parameter int WRITE_CYCLE_CYC = sep_pkg::WRITE_CYCLE_CYC
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// link
	sep_spi_if.device       spi,
	// user side
	output logic            busy,
	output logic [7:0]      statusByte,
	output logic            identLocked
);
	import sep_pkg::*;

	typedef struct packed {
		logic [2:0]  csS, sclkS;
		logic [1:0]  mosiS, holdS, wpS;
		logic        active, paused;
		logic [2:0]  bitCnt;
		logic [7:0]  shIn;
		sep_phase_e  ph;
		sep_kind_e   kind, wrKind;
		logic        addrCnt;
		logic [15:0] addr;
		logic [5:0]  dataCnt;
		logic [7:0]  statNew, txByte, txSh;
		logic [2:0]  txCnt;
		logic        miso, misoOen, permit, busy;
		logic [17:0] timer;
		logic        statLock;
		logic [1:0]  bp;
		logic        idLock;
		logic [31:0] bufMask;
	} sep_dev_s;

	sep_dev_s   s_q, s_d;
	logic [7:0] memArr [0:ARR_WORDS-1];
	logic [7:0] idPage [0:PAGE_BYTES-1];
	logic [7:0] pageBuf [0:PAGE_BYTES-1];
	logic       bufWe, commitArr, commitId;
	logic [4:0] bufIdx;
	logic       csRise, csFall, sclkRise, sclkFall;
	logic [7:0] shNew, stat;
	logic [15:0] addrNew;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic isProt(input logic [1:0] bp, input logic [10:0] a);
		case (bp)
			2'h1:    isProt = (a >= PROT_QUARTER);
			2'h2:    isProt = (a >= PROT_HALF);
			2'h3:    isProt = 1'b1;
			default: isProt = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] idInit(input int i);
		case (i)
			0:       idInit = ID_MAKER;
			1:       idInit = ID_FAMILY;
			2:       idInit = ID_DENSITY;
			default: idInit = ERASED_BYTE;
		endcase
	endfunction

	// status bits 6..4 stay zero
	assign stat = {s_q.statLock, 3'h0, s_q.bp, s_q.permit, s_q.busy};

	function automatic logic [7:0] rdByte(input sep_kind_e k, input logic [15:0] a);
		case (k)
			K_RDST:  rdByte = stat;
			K_RDARR: rdByte = memArr[a[10:0]];
			K_RDPG:  rdByte = idPage[a[4:0]];
			K_RDLK:  rdByte = {7'h0, s_q.idLock};
			default: rdByte = ERASED_BYTE;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		bufWe = 1'b0;
		commitArr = 1'b0;
		commitId = 1'b0;
		bufIdx = s_q.addr[4:0] + s_q.dataCnt[4:0];
		s_d.csS = {s_q.csS[1:0], spi.csN};
		s_d.sclkS = {s_q.sclkS[1:0], spi.sclk};
		s_d.mosiS = {s_q.mosiS[0], spi.mosi};
		s_d.holdS = {s_q.holdS[0], spi.holdN};
		s_d.wpS = {s_q.wpS[0], spi.wpN};
		csFall = s_q.csS[2] & ~s_q.csS[1];
		csRise = ~s_q.csS[2] & s_q.csS[1];
		sclkRise = ~s_q.sclkS[2] & s_q.sclkS[1];
		sclkFall = s_q.sclkS[2] & ~s_q.sclkS[1];
		shNew = {s_q.shIn[6:0], s_q.mosiS[1]};
		addrNew = {s_q.addr[7:0], shNew};
		// write cycle timer, runs whatever the select does
		if (s_q.busy)
		begin
			if (s_q.timer == 18'h0)
			begin
				s_d.busy = 1'b0;
				s_d.permit = 1'b0;
				if (s_q.wrKind == K_WRST)
				begin
					s_d.statLock = s_q.statNew[BIT_LOCK];
					s_d.bp = {s_q.statNew[BIT_PROT_HI], s_q.statNew[BIT_PROT_LO]};
				end
				if (s_q.wrKind == K_LOCK)
					s_d.idLock = 1'b1;
			end
			else
				s_d.timer = s_q.timer - 18'h1;
		end
		// hold entry and exit, clock low
		if (s_q.active && !s_q.paused && !s_q.holdS[1] && !s_q.sclkS[1])
			s_d.paused = 1'b1;
		if (s_q.paused && s_q.holdS[1] && !s_q.sclkS[1])
			s_d.paused = 1'b0;
		// a frame only opens on a falling select edge
		if (csFall)
		begin
			s_d.active = 1'b1;
			s_d.paused = 1'b0;
			s_d.bitCnt = 3'h0;
			s_d.ph = PH_OP;
			s_d.kind = K_NONE;
			s_d.addrCnt = 1'b0;
			s_d.dataCnt = 6'h0;
			s_d.txCnt = 3'h0;
			s_d.bufMask = 32'h0;
		end
		if (csRise)
		begin
			// paused frame is aborted, partial byte discards writes
			if (s_q.active && !s_q.paused && s_q.bitCnt == 3'h0)
			begin
				if (s_q.ph == PH_DONE && s_q.kind == K_SETWL)
					s_d.permit = 1'b1;
				if (s_q.ph == PH_DONE && s_q.kind == K_CLRWL)
					s_d.permit = 1'b0;
				// latch set, data present, not busy
				if (s_q.ph == PH_DATA && s_q.dataCnt != 6'h0 && s_q.permit && !s_q.busy)
				begin
					case (s_q.kind)
						K_WRST:
						begin
							s_d.busy = !(s_q.statLock && !s_q.wpS[1]);
						end
						K_WRARR:
						begin
							s_d.busy = !isProt(s_q.bp, s_q.addr[10:0]);
							commitArr = s_d.busy;
						end
						K_WRPG:
						begin
							s_d.busy = s_q.bp != BP_ALL && !s_q.idLock;
							commitId = s_d.busy;
						end
						K_LOCK:  s_d.busy = !s_q.idLock;
						default: s_d.busy = 1'b0;
					endcase
					s_d.wrKind = s_q.kind;
					s_d.timer = 18'(WRITE_CYCLE_CYC - 1);
				end
			end
			s_d.active = 1'b0;
			s_d.paused = 1'b0;
			s_d.misoOen = 1'b1;
		end
		// sample on the rising serial clock
		else if (sclkRise && s_q.active && !s_q.paused && s_q.ph != PH_WAIT)
		begin
			s_d.shIn = shNew;
			s_d.bitCnt = s_q.bitCnt + 3'h1;
			if (s_q.bitCnt == 3'h7)
			begin
				case (s_q.ph)
					PH_OP:
					begin
						s_d.ph = PH_ADDR;
						s_d.kind = K_NONE;
						case (shNew)
							OP_SET_WL:   {s_d.kind, s_d.ph} = {K_SETWL, PH_DONE};
							OP_CLR_WL:   {s_d.kind, s_d.ph} = {K_CLRWL, PH_DONE};
							OP_RD_STAT:  {s_d.kind, s_d.ph} = {K_RDST, PH_OUT};
							OP_WR_STAT:  {s_d.kind, s_d.ph} = {K_WRST, PH_DATA};
							OP_RD_ARR:   s_d.kind = K_RDARR;
							OP_WR_ARR:   s_d.kind = K_WRARR;
							OP_RD_IDENT: s_d.kind = K_RDPG;
							OP_WR_IDENT: s_d.kind = K_WRPG;
							default:     s_d.ph = PH_WAIT;
						endcase
						// array and id page reads are refused during a write cycle, status reads are not
						if (s_q.busy && (shNew == OP_RD_ARR || shNew == OP_RD_IDENT))
							s_d.ph = PH_WAIT;
						s_d.txByte = stat;
					end
					PH_ADDR:
					begin
						s_d.addr = addrNew;
						s_d.addrCnt = 1'b1;
						if (s_q.addrCnt)
						begin
							s_d.ph = PH_DATA;
							// bit 10 selects lock form, rest zero
							if ((s_q.kind == K_RDPG || s_q.kind == K_WRPG) && addrNew[ADDR_SEL])
							begin
								s_d.kind = (s_q.kind == K_RDPG) ? K_RDLK : K_LOCK;
								if ((addrNew & ~(16'h1 << ADDR_SEL)) != 16'h0)
									s_d.ph = PH_WAIT;
							end
							if (s_d.kind == K_RDARR || s_d.kind == K_RDPG || s_d.kind == K_RDLK)
							begin
								if (s_d.ph == PH_DATA)
									s_d.ph = PH_OUT;
								s_d.txByte = rdByte(s_d.kind, addrNew);
							end
						end
					end
					PH_DATA:
					begin
						if (s_q.dataCnt != 6'h3f)
							s_d.dataCnt = s_q.dataCnt + 6'h1;
						s_d.statNew = shNew;
						bufWe = 1'b1;
						s_d.bufMask = s_q.bufMask | (32'h1 << bufIdx);
					end
					PH_OUT:
					begin
						// array address wraps at 11 bits, id page reads wrap on the low 5 bits
						s_d.addr = (s_q.kind == K_RDARR) ? {5'h0, s_q.addr[10:0] + 11'h1} : s_q.addr + 16'h1;
						s_d.txByte = rdByte(s_q.kind, s_d.addr);
					end
					default: s_d.ph = PH_WAIT;
				endcase
			end
		end
		// drive on the falling serial clock
		else if (sclkFall && s_q.active && !s_q.paused && s_q.ph == PH_OUT)
		begin
			s_d.misoOen = 1'b0;
			s_d.txCnt = s_q.txCnt + 3'h1;
			if (s_q.txCnt == 3'h0)
			begin
				s_d.miso = s_q.txByte[7];
				s_d.txSh = {s_q.txByte[6:0], 1'b0};
			end
			else
			begin
				s_d.miso = s_q.txSh[7];
				s_d.txSh = {s_q.txSh[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.misoOen <= 1'b1;
			s_q.wpS <= 2'h3;
			s_q.holdS <= 2'h3;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (bufWe)
			pageBuf[bufIdx] <= shNew;
		for (int i = 0; i < PAGE_BYTES; i++)
			if (commitArr && s_q.bufMask[i])
				memArr[{s_q.addr[10:5], 5'(i)}] <= pageBuf[i];
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
				idPage[i] <= idInit(i);
		end
		else
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
				if (commitId && s_q.bufMask[i])
					idPage[i] <= pageBuf[i];
		end
	end

	assign spi.misoOut = s_q.miso;
	assign spi.misoOen = s_q.misoOen | s_q.paused;
	assign busy = s_q.busy;
	assign statusByte = stat;
	assign identLocked = s_q.idLock;
endmodule // sep_eeprom_dev
`default_nettype wire

// *** src/sep_spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sep_spi_host (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// register port
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic [7:0]      regRdata,
	// link
	sep_spi_if.host         spi
);
	import sep_pkg::*;

	typedef struct packed {
		logic [3:0]  ctrl;
		sep_hstate_e seq;
		logic [2:0]  bitCnt;
		logic [7:0]  halfCnt;
		logic [7:0]  txSh, rxSh, rxData, rdata;
		logic        csN, sclk, holdN, sel;
		logic [1:0]  misoS;
	} sep_host_s;

	sep_host_s s_q, s_d;
	logic      halfDone;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.misoS = {s_q.misoS[0], spi.miso};
		halfDone = s_q.halfCnt == 8'(SCLK_HALF_CYC - 1);
		s_d.halfCnt = halfDone ? 8'h0 : s_q.halfCnt + 8'h1;
		// register reads answer one cycle later
		if (regRd)
		begin
			case (regAddr)
				REG_CTRL: s_d.rdata = {4'h0, s_q.ctrl};
				REG_TX:   s_d.rdata = s_q.txSh;
				REG_RX:   s_d.rdata = s_q.rxData;
				default:  s_d.rdata = {6'h0, s_q.sel, s_q.seq != H_IDLE};
			endcase
		end
		if (regWr && regAddr == REG_CTRL)
			s_d.ctrl = regWdata[3:0];
		// hold only taken with the clock low
		s_d.holdN = !(s_d.ctrl[CTRL_HOLD] && !s_q.sclk);
		case (s_q.seq)
			H_IDLE:
			begin
				s_d.sclk = s_d.ctrl[CTRL_CPOL];
				s_d.halfCnt = 8'h0;
				if (regWr && regAddr == REG_TX)
				begin
					s_d.txSh = regWdata;
					s_d.csN = 1'b0;
					s_d.sel = 1'b1;
					s_d.sclk = 1'b0;
					s_d.bitCnt = 3'h0;
					s_d.seq = H_LO;
				end
				else if (regWr && regAddr == REG_CTRL && !regWdata[CTRL_KEEP] && s_q.sel)
					s_d.seq = H_END;
			end
			H_LO:
			begin
				if (!s_q.holdN)
					s_d.halfCnt = s_q.halfCnt;
				else if (halfDone)
				begin
					s_d.sclk = 1'b1;
					s_d.seq = H_HI;
				end
			end
			H_HI:
			begin
				if (halfDone)
				begin
					s_d.rxSh = {s_q.rxSh[6:0], s_q.misoS[1]};
					s_d.txSh = {s_q.txSh[6:0], 1'b0};
					s_d.bitCnt = s_q.bitCnt + 3'h1;
					s_d.sclk = 1'b0;
					s_d.seq = H_LO;
					// select only rises on a byte boundary
					if (s_q.bitCnt == 3'h7)
					begin
						s_d.rxData = {s_q.rxSh[6:0], s_q.misoS[1]};
						s_d.sclk = s_q.ctrl[CTRL_CPOL];
						s_d.seq = s_q.ctrl[CTRL_KEEP] ? H_IDLE : H_END;
					end
				end
			end
			default:
			begin
				if (halfDone)
				begin
					s_d.csN = 1'b1;
					s_d.sel = 1'b0;
					s_d.seq = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.csN <= 1'b1;
			s_q.holdN <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// address bytes and mode are sent as software writes them
	assign spi.csN = s_q.csN;
	assign spi.sclk = s_q.sclk;
	assign spi.mosi = s_q.txSh[7];
	assign spi.holdN = s_q.holdN;
	assign spi.wpN = !s_q.ctrl[CTRL_WP];
	assign regRdata = s_q.rdata;
endmodule // sep_spi_host
`default_nettype wire

// *** dv/sep_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sep_link_props (
	// clock and reset
	input wire logic       clock,
	input wire logic       rstn,
	// link
	input wire logic       csN,
	input wire logic       sclk,
	input wire logic       mosi,
	input wire logic       misoOut,
	input wire logic       misoOen,
	input wire logic       holdN,
	input wire logic       wpN,
	// device user side
	input wire logic       busy,
	input wire logic [7:0] statusByte
);
	// ----------------------------------------
	// link and status checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	a_deselect_float: assert property (csN [*6] |-> misoOen)
		else $error("link output driven while deselected");
	a_pause_float: assert property ((!holdN && !sclk) [*8] |-> misoOen)
		else $error("link output driven while paused");
	a_zero_bits: assert property (statusByte[6:4] == 3'b000)
		else $error("status bits six to four not zero");
	a_busy_mirror: assert property (statusByte[0] == busy)
		else $error("status busy bit differs from busy");
	a_busy_at_deselect: assert property ($rose(busy) |-> csN ##1 busy [*8])
		else $error("write cycle start or length wrong");
	a_latch_before_busy: assert property ($rose(busy) |-> $past(statusByte[1]))
		else $error("write cycle without write latch");
	a_latch_clear_end: assert property ($fell(busy) |-> ##[0:1] !statusByte[1])
		else $error("write latch kept after write cycle");
	a_protect_change: assert property ($changed({statusByte[7], statusByte[3:2]})
		|-> (busy || $past(busy) || $past(busy, 2)))
		else $error("protect bits changed outside a write cycle");
endmodule // sep_link_props
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sep_pkg::*;
	// ----------------------------------------
	// clock, reset and wiring
	// ----------------------------------------
	localparam int WR_CYC = 400;
	logic       clock       = 1'b0;
	logic       rstn        = 1'b0;
	logic [1:0] regAddr     = 2'h0;
	logic [7:0] regWdata    = 8'h00;
	logic       regWr       = 1'b0;
	logic       regRd       = 1'b0;
	logic [7:0] regRdata;
	logic       busy;
	logic [7:0] statusByte;
	logic       identLocked;
	logic [7:0] ctrlBase    = 8'h00;
	logic [7:0] mosiSh      = 8'h00;
	logic [7:0] rx;
	int         busyCyc     = 0;
	int         n_fail      = 0;
	int         check_count = 0;
	int         cyc         = 0;
	always #12.5 clock = ~clock;
	sep_spi_if spiBus ();
	sep_eeprom_dev #(.WRITE_CYCLE_CYC(WR_CYC)) sep_eeprom_dev_i (.clock(clock), .rstn(rstn), .spi(spiBus),
		.busy(busy), .statusByte(statusByte), .identLocked(identLocked));
	sep_spi_host sep_spi_host_i (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .spi(spiBus));
	sep_link_props sep_link_props_i (.clock(clock), .rstn(rstn), .csN(spiBus.csN), .sclk(spiBus.sclk),
		.mosi(spiBus.mosi), .misoOut(spiBus.misoOut), .misoOen(spiBus.misoOen), .holdN(spiBus.holdN),
		.wpN(spiBus.wpN), .busy(busy), .statusByte(statusByte));
	always @(posedge spiBus.sclk)
		if (!spiBus.csN)
			mosiSh <= {mosiSh[6:0], spiBus.mosi};
	always @(posedge clock)
	begin
		if (busy === 1'b1)
			busyCyc++;
		cyc++;
		if (cyc == 80000)
		begin
			n_fail++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic pollClear(input int b);
		logic [7:0] s;
		int         i;
		s = 8'hff;
		for (i = 0; i < 300 && s[b] !== 1'b0; i++)
			regRead(REG_STAT, s);
		check(s[b], 1'b0);
	endtask
	task automatic frame(input logic [7:0] b0, b1, b2, b3, input int n, output logic [7:0] r);
		logic [7:0] q [4];
		int         k;
		q = '{b0, b1, b2, b3};
		regWrite(REG_CTRL, ctrlBase | 8'h01);
		for (k = 0; k < n; k++)
		begin
			regWrite(REG_TX, q[k]);
			pollClear(0);
		end
		regRead(REG_RX, r);
		regWrite(REG_CTRL, ctrlBase);
		pollClear(1);
	endtask
	task automatic rdStat(input logic [7:0] exp);
		logic [7:0] r;
		frame(OP_RD_STAT, 8'h00, 8'h00, 8'h00, 2, r);
		check(r, exp);
	endtask
	task automatic waitWrite;
		int i;
		repeat (4) @(posedge clock);
		for (i = 0; i < 1000 && busy !== 1'b0; i++)
			@(posedge clock);
		check(busy, 1'b0);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int bc;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		rdStat(8'h00);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		check(mosiSh, OP_SET_WL);
		rdStat(8'h02);
		frame(OP_CLR_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		rdStat(8'h00);
		bc = busyCyc;
		frame(OP_WR_STAT, 8'h8c, 8'h00, 8'h00, 2, rx);
		rdStat(8'h00);
		check(busyCyc - bc, 0);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		bc = busyCyc;
		frame(OP_WR_ARR, 8'hf8, 8'h10, 8'h3c, 4, rx);
		rdStat(8'h03);
		waitWrite;
		check(busyCyc - bc, WR_CYC);
		rdStat(8'h00);
		frame(OP_RD_ARR, 8'h00, 8'h10, 8'h00, 4, rx);
		check(rx, 8'h3c);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		frame(OP_WR_STAT, 8'hfc, 8'h00, 8'h00, 2, rx);
		waitWrite;
		rdStat(8'h8c);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		frame(OP_WR_ARR, 8'h00, 8'h10, 8'h55, 4, rx);
		waitWrite;
		frame(OP_RD_ARR, 8'h00, 8'h10, 8'h00, 4, rx);
		check(rx, 8'h3c);
		ctrlBase = 8'h08;
		bc = busyCyc;
		frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2, rx);
		waitWrite;
		rdStat(8'h8e);
		check(busyCyc - bc, 0);
		ctrlBase = 8'h00;
		frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2, rx);
		waitWrite;
		rdStat(8'h00);
		frame(OP_RD_IDENT, 8'h00, 8'h00, 8'h00, 4, rx);
		check(rx, ID_MAKER);
		frame(OP_RD_IDENT, 8'h04, 8'h00, 8'h00, 4, rx);
		check(rx, 8'h00);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		frame(OP_WR_IDENT, 8'h00, 8'h05, 8'ha7, 4, rx);
		waitWrite;
		frame(OP_RD_IDENT, 8'h00, 8'h05, 8'h00, 4, rx);
		check(rx, 8'ha7);
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		frame(OP_WR_IDENT, 8'h04, 8'h00, 8'h00, 4, rx);
		waitWrite;
		check(identLocked, 1'b1);
		frame(OP_RD_IDENT, 8'h04, 8'h00, 8'h00, 4, rx);
		check(rx, 8'h01);
		frame(8'ha5, OP_SET_WL, 8'h00, 8'h00, 2, rx);
		rdStat(8'h00);
		ctrlBase = 8'h02;
		frame(OP_SET_WL, 8'h00, 8'h00, 8'h00, 1, rx);
		check(spiBus.sclk, 1'b1);
		rdStat(8'h02);
		ctrlBase = 8'h00;
		regWrite(REG_CTRL, 8'h01);
		regWrite(REG_TX, OP_RD_STAT);
		pollClear(0);
		regWrite(REG_TX, 8'h00);
		repeat (20) @(posedge clock);
		regWrite(REG_CTRL, 8'h05);
		repeat (40) @(posedge clock);
		check(spiBus.holdN, 1'b0);
		check(spiBus.misoOen, 1'b1);
		regWrite(REG_CTRL, 8'h01);
		pollClear(0);
		regRead(REG_RX, rx);
		check(rx, 8'h02);
		regWrite(REG_CTRL, 8'h00);
		pollClear(1);
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
